/* rtl/front_panel_status.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - four lamps encode base rate and pull
// - frames point lit on even fields
// - minutes point lit in auto source mode
// - display shows positional timecode hh:mm:ss:ff
// - auto mode lights both, then chosen lamp
// - positional switch steps through five choices
// - clock switch steps six sources, one lamp
// - exactly one of four frame-rate lamps
// - drop-frame lamp lit for drop-frame only
// - lock lamp steady while locked
// - lock lamp flashes when reference missing
// - rate lamp steady within 250 ppm
// - rate lamp flashes fast when too fast
// - rate lamp flashes slow when too slow
// - rate lamp from rates, not motion
// - remote lamp lit during panel lockout
// - pull options not tied to frame rate
// - firmware version shown at power up
// - four keys select and adjust parameters
// - no midi input path exists
module front_panel_status #(
    parameter int          FAST_HALF    = panel_pkg::CLK_HZ / panel_pkg::MS_PER_S * panel_pkg::FAST_FLASH_MS,
    parameter int          SLOW_HALF    = panel_pkg::CLK_HZ / panel_pkg::MS_PER_S * panel_pkg::SLOW_FLASH_MS,
    parameter int          LOCK_HALF    = panel_pkg::CLK_HZ / panel_pkg::MS_PER_S * panel_pkg::LOCK_FLASH_MS,
    parameter int          VERSION_SHOW = panel_pkg::CLK_HZ / panel_pkg::MS_PER_S * panel_pkg::VERSION_SHOW_MS,
    parameter logic [11:0] FW_VERSION   = 12'h123 // arbitrary value, three digits major.minor.patch
) (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clock_ref_step,
    input  wire logic                    pos_ref_step,
    input  wire logic                    frame_rate_step,
    input  wire logic                    set_key,
    input  wire logic                    down_key,
    input  wire logic                    up_key,
    input  wire logic                    run_halt_clear_key,
    input  wire logic                    front_panel_lockout,
    input  wire logic                    ref_locked,
    input  wire logic                    auto_deciding,
    input  wire logic                    auto_chose_vitc,
    input  wire logic                    field_even,
    input  wire logic [16:0]             measured_rate_hz,
    input  wire panel_pkg::timecode_t    timecode,
    output panel_pkg::panel_lamps_t      lamps,
    output panel_pkg::display_t          display,
    output panel_pkg::clock_ref_t        clock_ref_sel,
    output panel_pkg::pos_ref_t          pos_ref_sel,
    output panel_pkg::frame_sel_t        frame_sel,
    output logic [16:0]                  desired_rate_hz,
    output logic                         video_pal,
    output logic                         generator_run
);
    // ======
    // helpers
    // ======
    function automatic logic [16:0] rate_of(input logic base48, input panel_pkg::pull_t pull);
        logic [16:0] r;
        r = base48 ? panel_pkg::RATE_48000 : panel_pkg::RATE_44100;
        case (pull)
            panel_pkg::PULL_UP:   r = base48 ? panel_pkg::RATE_48048 : panel_pkg::RATE_44144;
            panel_pkg::PULL_DOWN: r = base48 ? panel_pkg::RATE_47952 : panel_pkg::RATE_44056;
            default:              r = r;
        endcase
        return r;
    endfunction : rate_of

    // deviation beyond the window means |diff| * 4000 > desired
    function automatic panel_pkg::rate_dev_t rate_dev(input logic [16:0] act, input logic [16:0] want);
        logic [16:0] diff;
        logic [29:0] scaled;
        diff   = (act >= want) ? act - want : want - act;
        scaled = 30'(diff) * 30'(panel_pkg::PPM_DIV);
        if (scaled <= 30'(want))
            return panel_pkg::DEV_IN;
        return (act > want) ? panel_pkg::DEV_HIGH : panel_pkg::DEV_LOW;
    endfunction : rate_dev

    // ======
    // key edge detection
    // ======
    logic [6:0] keys_q;
    logic [6:0] keys_d;
    logic [6:0] press;

    // a key counts once per push; lockout leaves the panel dead
    always_comb begin
        keys_d = {clock_ref_step, pos_ref_step, frame_rate_step, set_key, down_key, up_key, run_halt_clear_key};
        press  = front_panel_lockout ? 7'h00 : (keys_d & ~keys_q);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            keys_q <= 7'h00;
        end else begin
            keys_q <= keys_d;
        end
    end

    // ======
    // selections and parameters
    // ======
    panel_pkg::clock_ref_t  clk_q;
    panel_pkg::clock_ref_t  clk_d;
    panel_pkg::pos_ref_t    pos_q;
    panel_pkg::pos_ref_t    pos_d;
    panel_pkg::frame_sel_t  frm_q;
    panel_pkg::frame_sel_t  frm_d;
    panel_pkg::param_mode_t mode_q;
    panel_pkg::param_mode_t mode_d;
    panel_pkg::pull_t       pull_q;
    panel_pkg::pull_t       pull_d;
    logic                   base48_q;
    logic                   base48_d;
    logic                   pal_q;
    logic                   pal_d;
    logic                   run_q;
    logic                   run_d;

    // switches wrap round their choices; set walks the parameter modes
    always_comb begin
        clk_d    = clk_q;
        pos_d    = pos_q;
        frm_d    = frm_q;
        mode_d   = mode_q;
        pull_d   = pull_q;
        base48_d = base48_q;
        pal_d    = pal_q;
        run_d    = run_q;
        if (press[6])
            clk_d = (clk_q == panel_pkg::CK_VARISPEED) ? panel_pkg::CK_VIDEO
                                                     : panel_pkg::clock_ref_t'(clk_q + 3'h1);
        if (press[5])
            pos_d = (pos_q == panel_pkg::PR_GENERATE) ? panel_pkg::PR_LTC
                                                    : panel_pkg::pos_ref_t'(pos_q + 3'h1);
        if (press[4])
            frm_d = (frm_q == panel_pkg::FR_24) ? panel_pkg::FR_30
                                              : panel_pkg::frame_sel_t'(frm_q + 3'h1);
        if (press[3])
            mode_d = panel_pkg::param_mode_t'(mode_q + 2'h1);
        // up and down adjust whichever parameter is on show
        if (press[2] || press[1]) begin
            case (mode_q)
                panel_pkg::PM_RATE_BASE: base48_d = ~base48_q;
                panel_pkg::PM_VIDEO:     pal_d    = ~pal_q;
                panel_pkg::PM_PULL: begin
                    // pull is free of the frame rate, so no 24/25 conversion is implied
                    if (press[1])
                        pull_d = (pull_q == panel_pkg::PULL_DOWN) ? panel_pkg::PULL_NONE
                                                                : panel_pkg::pull_t'(pull_q + 2'h1);
                    else
                        pull_d = (pull_q == panel_pkg::PULL_NONE) ? panel_pkg::PULL_DOWN
                                                                : panel_pkg::pull_t'(pull_q - 2'h1);
                end
                default: pull_d = pull_q;
            endcase
        end
        // run/halt in timecode view, clear back to timecode elsewhere
        if (press[0]) begin
            if (mode_q == panel_pkg::PM_TIMECODE)
                run_d = ~run_q;
            else
                mode_d = panel_pkg::PM_TIMECODE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clk_q    <= panel_pkg::CK_VARISPEED;
            pos_q    <= panel_pkg::PR_GENERATE;
            frm_q    <= panel_pkg::FR_30;
            mode_q   <= panel_pkg::PM_TIMECODE;
            pull_q   <= panel_pkg::PULL_NONE;
            base48_q <= 1'b1;
            pal_q    <= 1'b0;
            run_q    <= 1'b0;
        end else begin
            clk_q    <= clk_d;
            pos_q    <= pos_d;
            frm_q    <= frm_d;
            mode_q   <= mode_d;
            pull_q   <= pull_d;
            base48_q <= base48_d;
            pal_q    <= pal_d;
            run_q    <= run_d;
        end
    end

    // ======
    // power-up version display
    // ======
    logic [31:0] boot_q;
    logic [31:0] boot_d;
    logic        booting;

    // counts from reset release; version holds until it expires
    always_comb begin
        booting = (boot_q < 32'(VERSION_SHOW));
        boot_d  = booting ? boot_q + 32'h1 : boot_q;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            boot_q <= 32'h0;
        end else begin
            boot_q <= boot_d;
        end
    end

    // ======
    // flash sources
    // ======
    logic fast_flash;
    logic slow_flash;
    logic lock_flash;

    // three fixed dividers; fast and slow kept far apart so they read distinctly
    lamp_flasher #(.HALF_CYCLES(FAST_HALF)) u_fast (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .flash   (fast_flash)
    );

    lamp_flasher #(.HALF_CYCLES(SLOW_HALF)) u_slow (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .flash   (slow_flash)
    );

    lamp_flasher #(.HALF_CYCLES(LOCK_HALF)) u_lock (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .flash   (lock_flash)
    );

    // ======
    // digit codes and segment encoding
    // ======
    logic [panel_pkg::NUM_DIGITS-1:0][4:0] code;
    logic [panel_pkg::NUM_DIGITS-1:0][6:0] seg_w;
    logic [panel_pkg::NUM_DIGITS-1:0]      dp_w;

    // version, then parameter view or the positional timecode
    always_comb begin
        code = {panel_pkg::NUM_DIGITS{panel_pkg::CODE_BLANK}};
        dp_w = '0;
        if (booting) begin
            code[2] = {1'b0, FW_VERSION[11:8]};
            code[1] = {1'b0, FW_VERSION[7:4]};
            code[0] = {1'b0, FW_VERSION[3:0]};
            dp_w[2] = 1'b1;
            dp_w[1] = 1'b1;
        end else if (mode_q != panel_pkg::PM_TIMECODE) begin
            code[7] = {3'h0, mode_q};
            case (mode_q)
                panel_pkg::PM_RATE_BASE: code[0] = {4'h0, base48_q};
                panel_pkg::PM_PULL:      code[0] = {3'h0, pull_q};
                default:                 code[0] = {4'h0, pal_q};
            endcase
        end else begin
            code[7] = {1'b0, timecode.hours[7:4]};
            code[6] = {1'b0, timecode.hours[3:0]};
            code[5] = {1'b0, timecode.minutes[7:4]};
            code[4] = {1'b0, timecode.minutes[3:0]};
            code[3] = {1'b0, timecode.seconds[7:4]};
            code[2] = {1'b0, timecode.seconds[3:0]};
            code[1] = {1'b0, timecode.frames[7:4]};
            code[0] = {1'b0, timecode.frames[3:0]};
            dp_w[panel_pkg::DP_FRAMES]  = field_even;
            dp_w[panel_pkg::DP_MINUTES] = (pos_q == panel_pkg::PR_AUTO);
        end
    end

    genvar g;
    generate
        for (g = 0; g < panel_pkg::NUM_DIGITS; g++) begin : g_digit
            digit_encoder u_enc (
                .code (code[g]),
                .seg  (seg_w[g])
            );
        end
    endgenerate

    // ======
    // lamp computation
    // ======
    panel_pkg::panel_lamps_t lamps_q;
    panel_pkg::panel_lamps_t lamps_d;
    panel_pkg::display_t     disp_q;
    panel_pkg::display_t     disp_d;
    logic [16:0]             want_q;
    logic [16:0]             want_d;
    panel_pkg::rate_dev_t    dev;

    // the match lamp sees only measured against wanted rate, never motion
    always_comb begin
        want_d  = rate_of(base48_q, pull_q);
        dev     = rate_dev(measured_rate_hz, want_q);
        lamps_d = '0;
        lamps_d.clock_ref[clk_q] = 1'b1;
        case (pos_q)
            panel_pkg::PR_LTC:     lamps_d.pos_ref[0] = 1'b1;
            panel_pkg::PR_VITC:    lamps_d.pos_ref[1] = 1'b1;
            panel_pkg::PR_BIPHASE: lamps_d.pos_ref[2] = 1'b1;
            panel_pkg::PR_AUTO: begin
                lamps_d.pos_ref[0] = auto_deciding | ~auto_chose_vitc;
                lamps_d.pos_ref[1] = auto_deciding | auto_chose_vitc;
            end
            default:               lamps_d.pos_ref[3] = 1'b1;
        endcase
        lamps_d.rate_441          = ~base48_q;
        lamps_d.rate_48           = base48_q;
        lamps_d.rate_raise_option = (pull_q == panel_pkg::PULL_UP);
        lamps_d.rate_lower_option = (pull_q == panel_pkg::PULL_DOWN);
        case (frm_q)
            panel_pkg::FR_30, panel_pkg::FR_30_DF:     lamps_d.frame_rate = 4'h1;
            panel_pkg::FR_2997, panel_pkg::FR_2997_DF: lamps_d.frame_rate = 4'h2;
            panel_pkg::FR_25:                          lamps_d.frame_rate = 4'h4;
            default:                                   lamps_d.frame_rate = 4'h8;
        endcase
        lamps_d.drop_frame_lamp = (frm_q == panel_pkg::FR_30_DF) || (frm_q == panel_pkg::FR_2997_DF);
        // an absent or out-of-range reference is never locked, so it flashes
        lamps_d.lock = ref_locked ? 1'b1 : lock_flash;
        case (dev)
            panel_pkg::DEV_IN:   lamps_d.rate_match_lamp = 1'b1;
            panel_pkg::DEV_HIGH: lamps_d.rate_match_lamp = fast_flash;
            default:             lamps_d.rate_match_lamp = slow_flash;
        endcase
        lamps_d.remote = front_panel_lockout;
        disp_d.seg = seg_w;
        disp_d.dp  = dp_w;
    end

    // every panel output is registered so lamps never glitch
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lamps_q <= '0;
            disp_q  <= '0;
            want_q  <= panel_pkg::RATE_48000;
        end else begin
            lamps_q <= lamps_d;
            disp_q  <= disp_d;
            want_q  <= want_d;
        end
    end

    // ======
    // outputs; timecode comes in on its own port and leaves only through the display
    // ======
    assign lamps           = lamps_q;
    assign display         = disp_q;
    assign clock_ref_sel   = clk_q;
    assign pos_ref_sel     = pos_q;
    assign frame_sel       = frm_q;
    assign desired_rate_hz = want_q;
    assign video_pal       = pal_q;
    assign generator_run   = run_q;

endmodule : front_panel_status

/* rtl/panel_pkg.sv */
package panel_pkg;

    // ======
    // timing
    // ======
    localparam int CLK_HZ          = 20_000_000;
    localparam int MS_PER_S        = 1000;
    localparam int FAST_FLASH_MS   = 100;  // half period of the fast flash
    localparam int SLOW_FLASH_MS   = 500;  // half period of the slow flash
    localparam int LOCK_FLASH_MS   = 250;  // half period of the lock lamp flash
    localparam int VERSION_SHOW_MS = 2000; // version shown after power up

    // ======
    // sample rates in hz and the match window
    // ======
    localparam logic [16:0] RATE_44100 = 17'h0ac44;
    localparam logic [16:0] RATE_48000 = 17'h0bb80;
    localparam logic [16:0] RATE_44144 = 17'h0ac70;
    localparam logic [16:0] RATE_44056 = 17'h0ac18;
    localparam logic [16:0] RATE_48048 = 17'h0bbb0;
    localparam logic [16:0] RATE_47952 = 17'h0bb50;
    localparam int          RATE_TOL_PPM = 250;
    localparam int          PPM_SCALE    = 1_000_000;
    localparam logic [12:0] PPM_DIV      = 13'(PPM_SCALE / RATE_TOL_PPM);

    // ======
    // selections
    // ======
    typedef enum logic [2:0] {CK_VIDEO, CK_LTC, CK_DIGITAL, CK_TONE, CK_TACH, CK_VARISPEED} clock_ref_t;
    typedef enum logic [2:0] {PR_LTC, PR_VITC, PR_AUTO, PR_BIPHASE, PR_GENERATE} pos_ref_t;
    typedef enum logic [2:0] {FR_30, FR_30_DF, FR_2997, FR_2997_DF, FR_25, FR_24} frame_sel_t;
    typedef enum logic [1:0] {PULL_NONE, PULL_UP, PULL_DOWN} pull_t;
    typedef enum logic [1:0] {PM_TIMECODE, PM_RATE_BASE, PM_PULL, PM_VIDEO} param_mode_t;
    typedef enum logic [1:0] {DEV_IN, DEV_HIGH, DEV_LOW} rate_dev_t;

    // ======
    // display layout: digit 0 is frames units, digit 7 hours tens
    // ======
    localparam int          NUM_DIGITS  = 8;
    localparam int          DP_FRAMES   = 0;
    localparam int          DP_MINUTES  = 4;
    localparam logic [4:0]  CODE_BLANK  = 5'h10;
    localparam logic [6:0]  SEG_BLANK   = 7'h00;

    typedef struct packed {
        logic [7:0] hours;   // bcd
        logic [7:0] minutes; // bcd
        logic [7:0] seconds; // bcd
        logic [7:0] frames;  // bcd
    } timecode_t;

    typedef struct packed {
        logic [5:0] clock_ref;  // one lamp per clock source
        logic [3:0] pos_ref;    // ltc, vitc, bi-phase, generate
        logic       rate_441;
        logic       rate_48;
        logic       rate_raise_option;
        logic       rate_lower_option;
        logic [3:0] frame_rate; // 30, 29.97, 25, 24
        logic       drop_frame_lamp;
        logic       lock;
        logic       rate_match_lamp;
        logic       remote;
    } panel_lamps_t;

    typedef struct packed {
        logic [NUM_DIGITS-1:0]      dp;
        logic [NUM_DIGITS-1:0][6:0] seg;
    } display_t;

endpackage : panel_pkg

/* rtl/lamp_flasher.sv */
`timescale 1ns/1ns
// ======
// square wave for flashing lamps, half period in clock cycles
// ======
module lamp_flasher #(
    parameter int HALF_CYCLES = 2_000_000
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    output logic      flash
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        flash_q;
    logic        flash_d;

    // wrap the divider and toggle at the end of each half period
    always_comb begin
        cnt_d   = cnt_q + 32'h1;
        flash_d = flash_q;
        if (cnt_q >= 32'(HALF_CYCLES - 1)) begin
            cnt_d   = 32'h0;
            flash_d = ~flash_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q   <= 32'h0;
            flash_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            flash_q <= flash_d;
        end
    end

    assign flash = flash_q;

endmodule : lamp_flasher

/* rtl/digit_encoder.sv */
`timescale 1ns/1ns
// ======
// hex digit to segments, gfedcba, anything above f is blank
// ======
module digit_encoder (
    input  wire logic [4:0] code,
    output logic      [6:0] seg
);
    always_comb begin
        case (code)
            5'h00:   seg = 7'h3f;
            5'h01:   seg = 7'h06;
            5'h02:   seg = 7'h5b;
            5'h03:   seg = 7'h4f;
            5'h04:   seg = 7'h66;
            5'h05:   seg = 7'h6d;
            5'h06:   seg = 7'h7d;
            5'h07:   seg = 7'h07;
            5'h08:   seg = 7'h7f;
            5'h09:   seg = 7'h6f;
            5'h0a:   seg = 7'h77;
            5'h0b:   seg = 7'h7c;
            5'h0c:   seg = 7'h39;
            5'h0d:   seg = 7'h5e;
            5'h0e:   seg = 7'h79;
            5'h0f:   seg = 7'h71;
            default: seg = panel_pkg::SEG_BLANK;
        endcase
    end

endmodule : digit_encoder

/* sim/panel_status_assertions.sv */
`timescale 1ns/1ns
// ======
// port checks for the front panel status block
// ======
module panel_status_assertions #(
    parameter int FAST_HALF    = 4,
    parameter int LOCK_HALF    = 10,
    parameter int VERSION_SHOW = 16
) (
    input wire logic                    sys_clk,
    input wire logic                    sys_rst,
    input wire logic                    front_panel_lockout,
    input wire logic                    ref_locked,
    input wire logic                    field_even,
    input wire logic [16:0]             measured_rate_hz,
    input wire panel_pkg::panel_lamps_t lamps,
    input wire panel_pkg::display_t     display,
    input wire panel_pkg::clock_ref_t   clock_ref_sel,
    input wire panel_pkg::pos_ref_t     pos_ref_sel,
    input wire panel_pkg::frame_sel_t   frame_sel,
    input wire logic [16:0]             desired_rate_hz
);
    localparam int FAST_WAIT = FAST_HALF + 1;
    localparam int LOCK_WAIT = 2 * LOCK_HALF + 2;
    logic [5:0] boot_q;
    logic       too_fast;
    logic       too_slow;
    logic       booted;
    // margin keeps flash checks off the window edge
    assign too_fast = measured_rate_hz > desired_rate_hz + 17'h00040;
    assign too_slow = measured_rate_hz + 17'h00040 < desired_rate_hz;
    assign booted   = boot_q > 6'(VERSION_SHOW + 2);
    // cycles since reset, saturating; point checks wait out the version view
    always_ff @(posedge sys_clk) begin
        boot_q <= sys_rst ? 6'h00 : (boot_q == 6'h3f ? boot_q : boot_q + 6'h01);
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    AST_LOCK_STEADY: assert property (ref_locked |=> lamps.lock) else $error("lock lamp not steady");
    AST_LOCK_FLASH: assert property ($fell(ref_locked) |-> ##[1:LOCK_WAIT] (!lamps.lock || ref_locked))
        else $error("lock lamp not flashing");
    AST_RATE_IN: assert property (measured_rate_hz == desired_rate_hz && $stable(desired_rate_hz)
        |=> lamps.rate_match_lamp) else $error("rate lamp dark in window");
    AST_RATE_FAST: assert property (too_fast [*3] |-> ##[1:FAST_WAIT]
        (!$stable(lamps.rate_match_lamp) || !too_fast)) else $error("fast flash too slow");
    AST_RATE_SLOW: assert property (too_slow [*3] ##0 $changed(lamps.rate_match_lamp)
        |=> (!too_slow || $stable(lamps.rate_match_lamp)) [*8]) else $error("slow flash too quick");
    AST_FRAMES_DP: assert property (booted |=> display.dp[0] == $past(field_even)) else $error("field point");
    AST_MINUTES_DP: assert property (booted |=> display.dp[4] ==
        ($past(pos_ref_sel) == panel_pkg::PR_AUTO)) else $error("auto point");
    AST_REMOTE: assert property (1 |=> lamps.remote == $past(front_panel_lockout)) else $error("remote lamp");
    AST_LOCKOUT: assert property (front_panel_lockout |=> $stable(clock_ref_sel) && $stable(pos_ref_sel))
        else $error("switch taken in lockout");
    AST_CLOCK_LAMP: assert property (1 |=> lamps.clock_ref == 6'(6'h01 << $past(clock_ref_sel)))
        else $error("clock lamp");
    AST_FRAME_LAMP: assert property (1 |=> $onehot(lamps.frame_rate)) else $error("frame lamps");
    AST_DROP: assert property (1 |=> lamps.drop_frame_lamp == ($past(frame_sel) == panel_pkg::FR_30_DF ||
        $past(frame_sel) == panel_pkg::FR_2997_DF)) else $error("drop frame lamp");
endmodule : panel_status_assertions

bind front_panel_status panel_status_assertions #(
    .FAST_HALF(FAST_HALF), .LOCK_HALF(LOCK_HALF), .VERSION_SHOW(VERSION_SHOW)
) chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .front_panel_lockout(front_panel_lockout), .ref_locked(ref_locked),
    .field_even(field_even), .measured_rate_hz(measured_rate_hz), .lamps(lamps), .display(display),
    .clock_ref_sel(clock_ref_sel), .pos_ref_sel(pos_ref_sel), .frame_sel(frame_sel),
    .desired_rate_hz(desired_rate_hz)
);

/* sim/panel_operator.sv */
`timescale 1ns/1ns
// ======
// operator at the panel: one short press per request
// ======
module panel_operator (
    input  wire logic       sys_clk,
    input  wire logic       press_go,
    input  wire logic [2:0] press_idx,
    output logic      [6:0] keys
);
    initial keys = 7'h00;
    // key springs back after one cycle, so every press is a clean edge
    always @(posedge sys_clk) begin
        keys <= press_go ? 7'(7'h01 << press_idx) : 7'h00;
    end
endmodule : panel_operator

/* sim/front_panel_status_bench.sv */
`timescale 1ns/1ns
// ======
// self-checking bench for the front panel status block
// ======
module front_panel_status_bench;
    logic sys_clk = 1'b0, sys_rst = 1'b1, go = 1'b0, lockout = 1'b0, locked = 1'b0;
    logic deciding = 1'b0, pick_vitc = 1'b0, even = 1'b0, pal, run;
    logic [2:0]  idx = 3'h0;
    logic [6:0]  keys;
    logic [16:0] meas = 17'h0bb80, want;
    panel_pkg::timecode_t    tc = 32'h01234567;
    panel_pkg::panel_lamps_t lamps;
    panel_pkg::display_t     disp;
    panel_pkg::clock_ref_t   ck_sel;
    panel_pkg::pos_ref_t     pr_sel;
    panel_pkg::frame_sel_t   fr_sel;
    int mismatches = 0, compares = 0, cyc = 0, flips;
    logic [6:0]  segs [8] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07};
    logic [4:0]  fr_tab [6] = '{5'h03, 5'h04, 5'h05, 5'h08, 5'h10, 5'h02};
    logic [3:0]  pr_tab [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
    // key, then {base and pull lamps, desired rate} expected after it
    logic [23:0] rate_tab [11] = '{24'h68bb80, 24'hb0ac44, 24'h70ac44, 24'hb4ac70, 24'hb2ac18, 24'hd2ac18,
                                   24'h72ac18, 24'haabb50, 24'h6abb50, 24'h8cbbb0, 24'h88bb80};

    always #25 sys_clk = ~sys_clk;

    panel_operator op (.sys_clk(sys_clk), .press_go(go), .press_idx(idx), .keys(keys));

    front_panel_status #(.FAST_HALF(4), .SLOW_HALF(20), .LOCK_HALF(10), .VERSION_SHOW(16)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clock_ref_step(keys[0]), .pos_ref_step(keys[1]),
        .frame_rate_step(keys[2]), .set_key(keys[3]), .down_key(keys[4]), .up_key(keys[5]),
        .run_halt_clear_key(keys[6]), .front_panel_lockout(lockout), .ref_locked(locked),
        .auto_deciding(deciding), .auto_chose_vitc(pick_vitc), .field_even(even), .measured_rate_hz(meas),
        .timecode(tc), .lamps(lamps), .display(disp), .clock_ref_sel(ck_sel), .pos_ref_sel(pr_sel),
        .frame_sel(fr_sel), .desired_rate_hz(want), .video_pal(pal), .generator_run(run));

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic press(input logic [2:0] k);
        idx = k;
        go = 1'b1;
        @(posedge sys_clk) #1 go = 1'b0;
        tick(3);
    endtask : press

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // counts lamp changes over 40 cycles; full periods make the count phase-free
    task automatic count_flips(input logic [16:0] rate, input int exp);
        logic prev;
        meas = rate;
        flips = 0;
        tick(3);
        prev = lamps.rate_match_lamp;
        repeat (40) begin
            tick(1);
            flips += int'(lamps.rate_match_lamp !== prev);
            prev = lamps.rate_match_lamp;
        end
        check(flips, exp);
    endtask : count_flips

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // hang guard, well above the sequence length
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        tick(5);
        sys_rst = 1'b0;
        tick(2);
        for (int i = 0; i < 8; i++) check(disp.seg[i], i < 3 ? segs[3 - i] : 7'h00);
        check(disp.dp, 8'h06);
        even = 1'b1;
        tick(20);
        for (int i = 0; i < 8; i++) check(disp.seg[i], segs[7 - i]);
        check(disp.dp, 8'h01);
        even = 1'b0;
        for (int i = 1; i <= 6; i++) begin
            press(3'h0);
            check(lamps.clock_ref, 6'h01 << ((5 + i) % 6));
        end
        for (int i = 0; i < 6; i++) begin
            press(3'h2);
            check({lamps.frame_rate, lamps.drop_frame_lamp}, fr_tab[i]);
        end
        deciding = 1'b1;
        for (int i = 0; i < 5; i++) begin
            press(3'h1);
            check(lamps.pos_ref, pr_tab[i]);
            if (i == 2) begin
                check(disp.dp[4], 1'b1);
                deciding = 1'b0;
                pick_vitc = 1'b1;
                tick(2);
                check(lamps.pos_ref, 4'h2);
                pick_vitc = 1'b0;
                tick(2);
                check(lamps.pos_ref, 4'h1);
                deciding = 1'b1;
            end
        end
        for (int i = 0; i < 11; i++) begin
            press(rate_tab[i][23:21]);
            check({lamps.rate_441, lamps.rate_48, lamps.rate_raise_option, lamps.rate_lower_option, want},
                  rate_tab[i][20:0]);
        end
        press(3'h3);
        press(3'h5);
        check(pal, 1'b1);
        press(3'h6);
        press(3'h6);
        check(run, 1'b1);
        lockout = 1'b1;
        press(3'h0);
        check({lamps.remote, ck_sel}, {1'b1, panel_pkg::CK_VARISPEED});
        lockout = 1'b0;
        locked = 1'b1;
        tick(3);
        check(lamps.lock, 1'b1);
        locked = 1'b0;
        flips = 0;
        tick(2);
        repeat (20) begin
            tick(1);
            flips += int'(lamps.lock === 1'b1);
        end
        check(flips, 10);
        count_flips(17'h0bb8c, 0);
        check(lamps.rate_match_lamp, 1'b1);
        count_flips(17'h0bb8d, 10);
        count_flips(17'h0bb73, 2);
        give_verdict();
    end
endmodule : front_panel_status_bench
